// >>> verilog/itmr_pkg.sv
package itmr_pkg;

    localparam logic [7:0] OFF_LOCAL_TEMP   = 8'h00;
    localparam logic [7:0] OFF_REMOTE_TEMP  = 8'h01;
    localparam logic [7:0] OFF_FLAGS        = 8'h02;
    localparam logic [7:0] OFF_LOCAL_UPPER  = 8'h0b;
    localparam logic [7:0] OFF_LOCAL_LOWER  = 8'h0c;
    localparam logic [7:0] OFF_REMOTE_UPPER = 8'h0d;
    localparam logic [7:0] OFF_REMOTE_LOWER = 8'h0e;
    localparam logic [7:0] OFF_REMOTE_CRIT  = 8'h19;
    localparam logic [7:0] OFF_LOCAL_CRIT   = 8'h20;
    localparam logic [7:0] OFF_HYST         = 8'h21;

    localparam logic [7:0] RST_UPPER = 8'h7f;
    localparam logic [7:0] RST_LOWER = 8'h80;
    localparam logic [7:0] RST_CRIT  = 8'h55;
    localparam logic [7:0] RST_HYST  = 8'h0a;

    localparam int FLG_LHIGH = 0;
    localparam int FLG_LLOW  = 1;
    localparam int FLG_RHIGH = 2;
    localparam int FLG_RLOW  = 3;
    localparam int FLG_LCRIT = 4;
    localparam int FLG_RCRIT = 5;

    localparam int NUM_CH    = 2;
    localparam int CH_LOCAL  = 0;
    localparam int CH_REMOTE = 1;

    localparam logic [2:0] BIT_LAST = 3'h7;

    typedef enum logic [3:0] {
        SEL_NONE   = 4'h0,
        SEL_LTEMP  = 4'h1,
        SEL_RTEMP  = 4'h2,
        SEL_FLAGS  = 4'h3,
        SEL_LUPPER = 4'h4,
        SEL_LLOWER = 4'h5,
        SEL_RUPPER = 4'h6,
        SEL_RLOWER = 4'h7,
        SEL_LCRIT  = 4'h8,
        SEL_RCRIT  = 4'h9,
        SEL_HYST   = 4'ha
    } itmr_sel_t;

    typedef enum logic [2:0] {
        LS_IDLE    = 3'h0,
        LS_DEVADDR = 3'h1,
        LS_ACK     = 3'h2,
        LS_WRITE   = 3'h3,
        LS_READ    = 3'h4,
        LS_RACK    = 3'h5
    } itmr_link_t;

    function automatic itmr_sel_t itmr_decode(input logic [7:0] ptr);
        case (ptr)
            OFF_LOCAL_TEMP:   return SEL_LTEMP;
            OFF_REMOTE_TEMP:  return SEL_RTEMP;
            OFF_FLAGS:        return SEL_FLAGS;
            OFF_LOCAL_UPPER:  return SEL_LUPPER;
            OFF_LOCAL_LOWER:  return SEL_LLOWER;
            OFF_REMOTE_UPPER: return SEL_RUPPER;
            OFF_REMOTE_LOWER: return SEL_RLOWER;
            OFF_LOCAL_CRIT:   return SEL_LCRIT;
            OFF_REMOTE_CRIT:  return SEL_RCRIT;
            OFF_HYST:         return SEL_HYST;
            default:          return SEL_NONE;
        endcase
    endfunction

endpackage

// >>> verilog/itmr_cmp_if.sv
interface itmr_cmp_if;
    logic [7:0] temp;
    logic [7:0] upper;
    logic [7:0] lower;
    logic [7:0] crit;
    logic [7:0] hyst;
    logic       high;
    logic       low;
    logic       crit_on;

    modport watch (input temp, upper, lower, crit, hyst, output high, low, crit_on);
    modport owner (output temp, upper, lower, crit, hyst, input high, low, crit_on);
endinterface

// >>> verilog/itmr_sync.sv
module itmr_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule // itmr_sync

// >>> verilog/itmr_watch.sv
module itmr_watch (
    input  wire logic clk,
    input  wire logic rstn,
    itmr_cmp_if.watch cmp
);
    logic signed [9:0] temp_x;
    logic signed [9:0] upper_x;
    logic signed [9:0] lower_x;
    logic signed [9:0] crit_x;
    logic signed [9:0] clear_x;

    // two guard bits keep crit minus hysteresis from wrapping
    assign temp_x  = {{2{cmp.temp[7]}}, cmp.temp};
    assign upper_x = {{2{cmp.upper[7]}}, cmp.upper};
    assign lower_x = {{2{cmp.lower[7]}}, cmp.lower};
    assign crit_x  = {{2{cmp.crit[7]}}, cmp.crit};
    assign clear_x = crit_x - $signed({2'b00, cmp.hyst});

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cmp.high <= 1'b0;
            cmp.low  <= 1'b0;
        end else begin
            cmp.high <= temp_x > upper_x;
            cmp.low  <= temp_x < lower_x;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cmp.crit_on <= 1'b0;
        end else if (temp_x > crit_x) begin
            cmp.crit_on <= 1'b1;
        end else if (temp_x <= clear_x) begin
            cmp.crit_on <= 1'b0;
        end
    end

    chk_crit_set: assert property (@(posedge clk) disable iff (!rstn)
        temp_x > crit_x |=> cmp.crit_on) else $error("crit not set above limit");
    chk_crit_hold: assert property (@(posedge clk) disable iff (!rstn)
        cmp.crit_on && temp_x > clear_x |=> cmp.crit_on) else $error("crit dropped inside hysteresis");
    chk_crit_drop: assert property (@(posedge clk) disable iff (!rstn)
        cmp.crit_on && temp_x <= clear_x && !(temp_x > crit_x) |=> !cmp.crit_on)
        else $error("crit held below hysteresis");
    chk_window_out: assert property (@(posedge clk) disable iff (!rstn)
        temp_x > upper_x || temp_x < lower_x |=> cmp.high || cmp.low) else $error("window miss");
endmodule // itmr_watch

// >>> verilog/itmr_top.sv
module itmr_top #(
    parameter logic [6:0] DEV_ADDR = 7'h48
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       scl,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    input  wire logic [7:0] local_temp,
    input  wire logic [7:0] remote_temp,
    output logic            alert_out,
    output logic            alert_oe_n,
    output logic            overheat_shutdown_out_n
);

    // ---- link side, clocked by scl ----

    itmr_pkg::itmr_link_t st;
    logic [7:0]           shreg;
    logic                 sda_hi;
    logic [2:0]           cnt;
    logic                 rw;
    logic                 first;
    logic [7:0]           ptr;
    logic [7:0]           cmd_byte;
    logic                 cmd_data;
    logic                 cmd_tgl;
    logic                 ack_tgl;
    logic [7:0]           txsh;
    logic [7:0]           rd_byte;
    logic                 rd_ack;
    logic                 rd_req_s;
    logic                 start_det;
    logic                 stop_det;
    logic                 done;
    logic                 addr_hit;
    logic                 tx_load;

    // ---- register side, clocked by clk ----

    logic [7:0]           temp_q    [0:itmr_pkg::NUM_CH-1];
    logic [7:0]           upper_lim [0:itmr_pkg::NUM_CH-1];
    logic [7:0]           lower_lim [0:itmr_pkg::NUM_CH-1];
    logic [7:0]           crit_lim  [0:itmr_pkg::NUM_CH-1];
    logic [7:0]           hyst;
    logic [7:0]           ptr_c;
    logic [7:0]           flags;
    logic [7:0]           live;
    logic [7:0]           rdata;
    logic [7:0]           rd_hold;
    logic                 rd_req;
    logic [2:0]           sync_q;
    logic [1:0]           sync_prev;
    logic                 cmd_ev;
    logic                 ack_ev;
    logic                 rd_load;
    logic                 cond;
    logic [itmr_pkg::NUM_CH-1:0] ch_high;
    logic [itmr_pkg::NUM_CH-1:0] ch_low;
    logic [itmr_pkg::NUM_CH-1:0] ch_crit;

    // open-drain pins only ever pull low
    assign sda_out   = 1'b0;
    assign alert_out = 1'b0;

    // sda moving while scl is high: seen as a mismatch at the falling edge
    assign start_det = sda_hi && !sda_in;
    assign stop_det  = !sda_hi && sda_in;
    assign done      = cnt == itmr_pkg::BIT_LAST;
    assign addr_hit  = shreg[7:1] == DEV_ADDR;
    assign tx_load   = (st == itmr_pkg::LS_ACK && rw) ||
                       (st == itmr_pkg::LS_RACK && !shreg[0]);

    always_ff @(posedge scl or negedge rstn) begin
        if (!rstn) begin
            shreg  <= 8'h00;
            sda_hi <= 1'b1;
        end else begin
            shreg  <= {shreg[6:0], sda_in};
            sda_hi <= sda_in;
        end
    end

    always_ff @(negedge scl or negedge rstn) begin
        if (!rstn) begin
            st    <= itmr_pkg::LS_IDLE;
            cnt   <= 3'h0;
            rw    <= 1'b0;
            first <= 1'b0;
        end else if (start_det) begin
            st  <= itmr_pkg::LS_DEVADDR;
            cnt <= 3'h0;
        end else if (stop_det) begin
            st <= itmr_pkg::LS_IDLE;
        end else begin
            case (st)
                itmr_pkg::LS_DEVADDR: begin
                    cnt <= 3'(cnt + 3'h1);
                    if (done) begin
                        st    <= addr_hit ? itmr_pkg::LS_ACK : itmr_pkg::LS_IDLE;
                        rw    <= shreg[0];
                        first <= 1'b1;
                    end
                end
                itmr_pkg::LS_WRITE: begin
                    cnt <= 3'(cnt + 3'h1);
                    if (done) begin
                        st    <= itmr_pkg::LS_ACK;
                        first <= 1'b0;
                    end
                end
                itmr_pkg::LS_ACK: begin
                    cnt <= 3'h0;
                    st  <= rw ? itmr_pkg::LS_READ : itmr_pkg::LS_WRITE;
                end
                itmr_pkg::LS_READ: begin
                    cnt <= 3'(cnt + 3'h1);
                    if (done) begin
                        st <= itmr_pkg::LS_RACK;
                    end
                end
                itmr_pkg::LS_RACK: begin
                    cnt <= 3'h0;
                    // a nack from the master ends the read
                    st  <= shreg[0] ? itmr_pkg::LS_IDLE : itmr_pkg::LS_READ;
                end
                default: begin
                    st <= itmr_pkg::LS_IDLE;
                end
            endcase
        end
    end

    always_ff @(negedge scl or negedge rstn) begin
        if (!rstn) begin
            sda_oe_n <= 1'b1;
            txsh     <= 8'h00;
        end else if (start_det || stop_det) begin
            sda_oe_n <= 1'b1;
        end else if (tx_load) begin
            txsh     <= rd_byte;
            sda_oe_n <= rd_byte[7];
        end else begin
            case (st)
                itmr_pkg::LS_DEVADDR: sda_oe_n <= !(done && addr_hit);
                itmr_pkg::LS_WRITE:   sda_oe_n <= !done;
                itmr_pkg::LS_READ: begin
                    sda_oe_n <= done ? 1'b1 : txsh[6];
                    txsh     <= {txsh[6:0], 1'b0};
                end
                default:              sda_oe_n <= 1'b1;
            endcase
        end
    end

    // payload stays put for a whole byte time, long after the toggle lands
    always_ff @(negedge scl or negedge rstn) begin
        if (!rstn) begin
            ptr      <= 8'h00;
            cmd_byte <= 8'h00;
            cmd_data <= 1'b0;
            cmd_tgl  <= 1'b0;
        end else if (!start_det && !stop_det && st == itmr_pkg::LS_WRITE && done) begin
            cmd_byte <= shreg;
            cmd_data <= !first;
            cmd_tgl  <= !cmd_tgl;
            if (first) begin
                ptr <= shreg;
            end
        end
    end

    always_ff @(negedge scl or negedge rstn) begin
        if (!rstn) begin
            ack_tgl <= 1'b0;
        end else if (!start_det && !stop_det && st == itmr_pkg::LS_READ && done &&
                     ptr == itmr_pkg::OFF_FLAGS) begin
            ack_tgl <= !ack_tgl;
        end
    end

    itmr_sync #(.W(1)) u_sync_link (
        .clk  (!scl),
        .rstn (rstn),
        .d    (rd_req),
        .q    (rd_req_s)
    );

    always_ff @(negedge scl or negedge rstn) begin
        if (!rstn) begin
            rd_byte <= 8'h00;
            rd_ack  <= 1'b0;
        end else if (rd_req_s != rd_ack) begin
            rd_byte <= rd_hold;
            rd_ack  <= rd_req_s;
        end
    end

    // ---- register side ----

    itmr_sync #(.W(3)) u_sync_reg (
        .clk  (clk),
        .rstn (rstn),
        .d    ({cmd_tgl, ack_tgl, rd_ack}),
        .q    (sync_q)
    );

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync_prev <= 2'b00;
        end else begin
            sync_prev <= sync_q[2:1];
        end
    end

    assign cmd_ev  = sync_q[2] != sync_prev[1];
    assign ack_ev  = sync_q[1] != sync_prev[0];
    assign rd_load = sync_q[0] == rd_req;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            temp_q[itmr_pkg::CH_LOCAL]  <= 8'h00;
            temp_q[itmr_pkg::CH_REMOTE] <= 8'h00;
        end else begin
            temp_q[itmr_pkg::CH_LOCAL]  <= local_temp;
            temp_q[itmr_pkg::CH_REMOTE] <= remote_temp;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ptr_c <= 8'h00;
        end else if (cmd_ev) begin
            ptr_c <= ptr;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < itmr_pkg::NUM_CH; i++) begin
                upper_lim[i] <= itmr_pkg::RST_UPPER;
                lower_lim[i] <= itmr_pkg::RST_LOWER;
                crit_lim[i]  <= itmr_pkg::RST_CRIT;
            end
            hyst <= itmr_pkg::RST_HYST;
        end else if (cmd_ev && cmd_data) begin
            case (itmr_pkg::itmr_decode(ptr))
                itmr_pkg::SEL_LUPPER: upper_lim[itmr_pkg::CH_LOCAL]  <= cmd_byte;
                itmr_pkg::SEL_LLOWER: lower_lim[itmr_pkg::CH_LOCAL]  <= cmd_byte;
                itmr_pkg::SEL_RUPPER: upper_lim[itmr_pkg::CH_REMOTE] <= cmd_byte;
                itmr_pkg::SEL_RLOWER: lower_lim[itmr_pkg::CH_REMOTE] <= cmd_byte;
                itmr_pkg::SEL_LCRIT:  crit_lim[itmr_pkg::CH_LOCAL]   <= cmd_byte;
                itmr_pkg::SEL_RCRIT:  crit_lim[itmr_pkg::CH_REMOTE]  <= cmd_byte;
                itmr_pkg::SEL_HYST:   hyst                           <= cmd_byte;
                default: begin
                end
            endcase
        end
    end

    itmr_cmp_if ch [itmr_pkg::NUM_CH] ();

    genvar g;
    generate
        for (g = 0; g < itmr_pkg::NUM_CH; g = g + 1) begin : g_ch
            assign ch[g].temp  = temp_q[g];
            assign ch[g].upper = upper_lim[g];
            assign ch[g].lower = lower_lim[g];
            assign ch[g].crit  = crit_lim[g];
            assign ch[g].hyst  = hyst;
            assign ch_high[g]  = ch[g].high;
            assign ch_low[g]   = ch[g].low;
            assign ch_crit[g]  = ch[g].crit_on;

            itmr_watch u_watch (
                .clk  (clk),
                .rstn (rstn),
                .cmp  (ch[g].watch)
            );
        end
    endgenerate

    assign live[itmr_pkg::FLG_LHIGH] = ch_high[itmr_pkg::CH_LOCAL];
    assign live[itmr_pkg::FLG_LLOW]  = ch_low[itmr_pkg::CH_LOCAL];
    assign live[itmr_pkg::FLG_RHIGH] = ch_high[itmr_pkg::CH_REMOTE];
    assign live[itmr_pkg::FLG_RLOW]  = ch_low[itmr_pkg::CH_REMOTE];
    assign live[itmr_pkg::FLG_LCRIT] = ch_crit[itmr_pkg::CH_LOCAL];
    assign live[itmr_pkg::FLG_RCRIT] = ch_crit[itmr_pkg::CH_REMOTE];
    assign live[7:6]                 = 2'b00;
    assign cond = |{ch_high, ch_low};

    // sticky flags; on acknowledge they reload the live state so nothing is lost
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flags <= 8'h00;
        end else if (ack_ev) begin
            flags <= live;
        end else begin
            flags <= flags | live;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            alert_oe_n <= 1'b1;
        end else if (ack_ev) begin
            alert_oe_n <= 1'b1;
        end else if (cond) begin
            alert_oe_n <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            overheat_shutdown_out_n <= 1'b1;
        end else begin
            overheat_shutdown_out_n <= !(|ch_crit);
        end
    end

    always_comb begin
        case (itmr_pkg::itmr_decode(ptr_c))
            itmr_pkg::SEL_LTEMP:  rdata = temp_q[itmr_pkg::CH_LOCAL];
            itmr_pkg::SEL_RTEMP:  rdata = temp_q[itmr_pkg::CH_REMOTE];
            itmr_pkg::SEL_FLAGS:  rdata = flags;
            itmr_pkg::SEL_LUPPER: rdata = upper_lim[itmr_pkg::CH_LOCAL];
            itmr_pkg::SEL_LLOWER: rdata = lower_lim[itmr_pkg::CH_LOCAL];
            itmr_pkg::SEL_RUPPER: rdata = upper_lim[itmr_pkg::CH_REMOTE];
            itmr_pkg::SEL_RLOWER: rdata = lower_lim[itmr_pkg::CH_REMOTE];
            itmr_pkg::SEL_LCRIT:  rdata = crit_lim[itmr_pkg::CH_LOCAL];
            itmr_pkg::SEL_RCRIT:  rdata = crit_lim[itmr_pkg::CH_REMOTE];
            itmr_pkg::SEL_HYST:   rdata = hyst;
            default:              rdata = 8'h00;
        endcase
    end

    // read byte is refreshed in a loop; it only advances while scl toggles
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_hold <= 8'h00;
            rd_req  <= 1'b0;
        end else if (rd_load) begin
            rd_hold <= rdata;
            rd_req  <= !rd_req;
        end
    end

    sequence s_ack_then_cond;
        ack_ev ##1 (cond && !ack_ev);
    endsequence

    chk_ptr_kept: assert property (@(posedge clk) disable iff (!rstn)
        ptr_c != $past(ptr_c) |-> $past(cmd_ev)) else $error("pointer moved without write");
    chk_local_read: assert property (@(posedge clk) disable iff (!rstn)
        rd_load && ptr_c == itmr_pkg::OFF_LOCAL_TEMP |=> rd_hold == $past(temp_q[itmr_pkg::CH_LOCAL]))
        else $error("local temp readback wrong");
    chk_remote_read: assert property (@(posedge clk) disable iff (!rstn)
        rd_load && ptr_c == itmr_pkg::OFF_REMOTE_TEMP |=> rd_hold == $past(temp_q[itmr_pkg::CH_REMOTE]))
        else $error("remote temp readback wrong");
    chk_alert_drive: assert property (@(posedge clk) disable iff (!rstn)
        cond && !ack_ev |=> !alert_oe_n) else $error("alert not driven");
    chk_ack_release: assert property (@(posedge clk) disable iff (!rstn)
        ack_ev |=> alert_oe_n) else $error("alert not released on ack");
    chk_reassert: assert property (@(posedge clk) disable iff (!rstn)
        s_ack_then_cond |=> !alert_oe_n) else $error("alert not reasserted");
    chk_crit_pin: assert property (@(posedge clk) disable iff (!rstn)
        |ch_crit |=> !overheat_shutdown_out_n ##0 (overheat_shutdown_out_n == !(|$past(ch_crit))))
        else $error("shutdown pin wrong");
    chk_reset_vals: assert property (@(posedge clk) disable iff (!rstn)
        $rose(rstn) |-> crit_lim[itmr_pkg::CH_LOCAL] == itmr_pkg::RST_CRIT && hyst == itmr_pkg::RST_HYST)
        else $error("bad reset values");
    chk_limit_write: assert property (@(posedge clk) disable iff (!rstn)
        cmd_ev && cmd_data && ptr == itmr_pkg::OFF_LOCAL_UPPER |=> upper_lim[itmr_pkg::CH_LOCAL] == $past(cmd_byte))
        else $error("upper limit not written");
    chk_status_ack: assert property (@(negedge scl) disable iff (!rstn)
        !start_det && !stop_det && st == itmr_pkg::LS_READ && done && ptr == itmr_pkg::OFF_FLAGS
        |=> ack_tgl != $past(ack_tgl)) else $error("flags read not acknowledged");

endmodule // itmr_top

// >>> verif/itmr_master.sv
module itmr_master #(
    parameter logic [6:0] DEV = 7'h48
) (
    output logic      scl,
    output logic      sda_rel,
    input  wire logic sda_w
);
    timeunit 1ns;
    timeprecision 1ps;
    int nacks = 0;
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    // data bits move only while scl is low, start and stop move sda while it is high; scl stands high outside frames
    task automatic clk_bit(input logic b, output logic r);
        sda_rel = b;
        #16 scl = 1'b1;
        #16 r = sda_w;
        #16 scl = 1'b0;
        #16;
    endtask
    task automatic start();
        sda_rel = 1'b1;
        #16 scl = 1'b1;
        #16 sda_rel = 1'b0;
        #32 scl = 1'b0;
        #16;
    endtask
    // the engine only sees a stop at the following scl fall, so one idle pulse follows
    task automatic stop();
        sda_rel = 1'b0;
        #16 scl = 1'b1;
        #16 sda_rel = 1'b1;
        #32 scl = 1'b0;
        #32 scl = 1'b1;
        #32;
    endtask
    task automatic put(input logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(v[i], r);
        clk_bit(1'b1, r);
        if (r !== 1'b0) nacks++;
    endtask
    task automatic read_again(output logic [7:0] d);
        logic r;
        start();
        put({DEV, 1'b1});
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
        clk_bit(1'b1, r);
        stop();
    endtask
    task automatic write_reg(input logic [7:0] p, input logic [7:0] d);
        start();
        put({DEV, 1'b0});
        put(p);
        put(d);
        stop();
    endtask
    task automatic read_reg(input logic [7:0] p, output logic [7:0] d);
        start();
        put({DEV, 1'b0});
        put(p);
        stop();
        read_again(d);
    endtask
endmodule // itmr_master

// >>> verif/i2c_temp_monitor_regs_tb.sv
module i2c_temp_monitor_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk  = 1'b0;
    logic       rstn = 1'b0;
    logic [7:0] lt   = 8'h19;
    logic [7:0] rt   = 8'h14;
    logic [7:0] rd;
    logic       scl;
    logic       sda_rel;
    logic       sda_oe_n;
    logic       alert_oe_n;
    logic       shut_n;
    logic       sda_drv;
    logic       alert_lvl;
    int         miscompares = 0;
    int         check_count = 0;
    int         cycles      = 0;
    // only the master or a low drive with its enable active pulls sda; otherwise the pull-up wins
    wire        sda_w = sda_rel & (sda_oe_n | sda_drv);
    always #12.5 clk = ~clk;
    itmr_top itmr_top_i (.clk(clk), .rstn(rstn), .scl(scl), .sda_in(sda_w), .sda_out(sda_drv), .sda_oe_n(sda_oe_n),
        .local_temp(lt), .remote_temp(rt), .alert_out(alert_lvl), .alert_oe_n(alert_oe_n),
        .overheat_shutdown_out_n(shut_n));
    itmr_master itmr_master_i (.scl(scl), .sda_rel(sda_rel), .sda_w(sda_w));
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp_byte(input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected byte at %0t: exp %h got %h", $time, exp, got);
        end
    endtask
    task automatic cmp_pin(input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected pin at %0t: exp %h got %h", $time, exp, got);
        end
    endtask
    task automatic reg_chk(input logic [7:0] p, input logic [7:0] exp);
        itmr_master_i.read_reg(p, rd);
        cmp_byte(exp, rd);
    endtask
    // outputs follow a reading within three clk edges; two spare edges are allowed
    task automatic set_temps(input logic [7:0] lv, input logic [7:0] rv);
        @(posedge clk);
        lt <= lv;
        rt <= rv;
        repeat (5) @(posedge clk);
        #1;
    endtask
    task automatic t_reset_values();
        cmp_pin(1'b1, alert_oe_n);
        cmp_pin(1'b0, alert_lvl);
        cmp_pin(1'b1, shut_n);
        reg_chk(8'h20, 8'h55);
        reg_chk(8'h21, 8'h0a);
    endtask
    task automatic t_access();
        reg_chk(8'h00, 8'h19);
        itmr_master_i.write_reg(8'h00, 8'h77);
        itmr_master_i.read_again(rd);
        cmp_byte(8'h19, rd);
        reg_chk(8'h01, 8'h14);
        itmr_master_i.write_reg(8'h0b, 8'h3c);
        itmr_master_i.write_reg(8'h0c, 8'h0a);
        reg_chk(8'h0b, 8'h3c);
        reg_chk(8'h0c, 8'h0a);
    endtask
    task automatic t_alert();
        set_temps(8'h46, 8'h46);
        cmp_pin(1'b0, alert_oe_n);
        set_temps(8'h19, 8'h14);
        cmp_pin(1'b0, alert_oe_n);
        reg_chk(8'h02, 8'h01);
        set_temps(8'h19, 8'h14);
        cmp_pin(1'b1, alert_oe_n);
        set_temps(8'h05, 8'h14);
        cmp_pin(1'b0, alert_oe_n);
        reg_chk(8'h02, 8'h02);
        set_temps(8'h05, 8'h14);
        cmp_pin(1'b0, alert_oe_n);
        set_temps(8'h19, 8'h14);
        itmr_master_i.read_again(rd);
        cmp_byte(8'h02, rd);
        set_temps(8'h19, 8'h14);
        cmp_pin(1'b1, alert_oe_n);
    endtask
    task automatic t_critical();
        itmr_master_i.write_reg(8'h20, 8'h4b);
        itmr_master_i.write_reg(8'h21, 8'h14);
        reg_chk(8'h19, 8'h55);
        set_temps(8'h50, 8'h14);
        cmp_pin(1'b0, shut_n);
        set_temps(8'h38, 8'h14);
        cmp_pin(1'b0, shut_n);
        set_temps(8'h37, 8'h14);
        cmp_pin(1'b1, shut_n);
        set_temps(8'h19, 8'h50);
        cmp_pin(1'b1, shut_n);
        set_temps(8'h19, 8'h56);
        cmp_pin(1'b0, shut_n);
        set_temps(8'h19, 8'h14);
        cmp_pin(1'b1, shut_n);
    endtask
    // a frame to another address must be ignored: every byte goes unacknowledged
    task automatic t_foreign();
        itmr_master_i.start();
        itmr_master_i.put({7'h55, 1'b0});
        itmr_master_i.put(8'h0b);
        itmr_master_i.put(8'h11);
        itmr_master_i.stop();
        cmp_byte(8'h03, 8'(itmr_master_i.nacks));
        reg_chk(8'h0b, 8'h3c);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        t_reset_values();
        t_access();
        t_alert();
        t_critical();
        cmp_byte(8'h00, 8'(itmr_master_i.nacks));
        t_foreign();
        end_of_test();
    end
endmodule // i2c_temp_monitor_regs_tb
